/* File: step_motion.sv */
// Motion sequencer: push-mode homing, position preset and continuous run.
// Assumes synchronous discrete inputs and an AXI4-Lite master on one clock.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "step_consts.svh"

module step_motion #(
    parameter int unsigned HALT_CYCLES = `HALT_MS * (`CLK_HZ / 1000),
    parameter int unsigned N_ENTRIES = 64
) (
    input wire logic CLK, // 25 MHz clock
    input wire logic RST_N, // Async reset, active low
    input wire step_pkg::axil_req_t AXI_REQ, // AXI4-Lite master side
    output var step_pkg::axil_rsp_t AXI_RSP, // AXI4-Lite slave answers
    input wire step_pkg::io_in_t IO_IN, // Host discrete inputs and sensors
    output var step_pkg::motor_out_t MOTOR // Step generator and flags
);
    import step_pkg::*;

    localparam logic [25:0] PHASE_WRAP = 26'(`CLK_HZ);
    localparam logic [20:0] RAMP_STEP = 21'(`CLK_NS);

    // ==========================================================
    // Address decoding and byte merge
    function automatic logic tbl_hit(input logic [11:0] a);
        tbl_hit = (a[11:10] == `TBL_SEL) && (a[3:2] != 2'h3);
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a[11:5] == 7'h00) || tbl_hit(a);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        merge = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
    endfunction

    // ==========================================================
    // AXI4-Lite slave
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, rd_d;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_en;

    // Both halves held and no answer pending
    assign wr_en = !awready_q && !wready_q && !bvalid_q;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (AXI_REQ.awvalid && awready_q) begin
                awaddr_q <= AXI_REQ.awaddr;
                awready_q <= 1'b0;
            end
            if (AXI_REQ.wvalid && wready_q) begin
                wdata_q <= AXI_REQ.wdata;
                wstrb_q <= AXI_REQ.wstrb;
                wready_q <= 1'b0;
            end
            if (wr_en) begin
                bvalid_q <= 1'b1;
                bresp_q <= is_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid_q && AXI_REQ.bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end else begin
            if (AXI_REQ.arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_d;
                rresp_q <= is_mapped(AXI_REQ.araddr) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (rvalid_q && AXI_REQ.rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign AXI_RSP = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
                       bresp: bresp_q, arready: arready_q, rvalid: rvalid_q,
                       rdata: rdata_q, rresp: rresp_q};

    // ==========================================================
    // Configuration registers
    logic [4:0] ctrl_q;
    logic home_go_q;
    logic signed [23:0] preset_q;
    logic [19:0] vs_q, vr_q, cacc_q, cdec_q;
    logic [31:0] wmerged;
    logic [19:0] spd_q [N_ENTRIES];
    logic [19:0] acc_q [N_ENTRIES];
    logic [19:0] dec_q [N_ENTRIES];

    always_comb begin
        wmerged = 32'h0000_0000;
        case (awaddr_q)
            `REG_CTRL: wmerged = merge({27'h000_0000, ctrl_q}, wdata_q, wstrb_q);
            `REG_PRESET: wmerged = merge({{8{preset_q[23]}}, preset_q}, wdata_q, wstrb_q);
            `REG_SEEK_START: wmerged = merge({12'h000, vs_q}, wdata_q, wstrb_q);
            `REG_SEEK_RUN: wmerged = merge({12'h000, vr_q}, wdata_q, wstrb_q);
            `REG_COMMON_ACC: wmerged = merge({12'h000, cacc_q}, wdata_q, wstrb_q);
            `REG_COMMON_DEC: wmerged = merge({12'h000, cdec_q}, wdata_q, wstrb_q);
            default: begin
                case (awaddr_q[3:2])
                    2'h0: wmerged = merge({12'h000, spd_q[awaddr_q[9:4]]}, wdata_q, wstrb_q);
                    2'h1: wmerged = merge({12'h000, acc_q[awaddr_q[9:4]]}, wdata_q, wstrb_q);
                    default: wmerged = merge({12'h000, dec_q[awaddr_q[9:4]]}, wdata_q, wstrb_q);
                endcase
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= 5'h00;
            home_go_q <= 1'b0;
            preset_q <= `PRESET_RST;
            vs_q <= `SEEK_START_RST;
            vr_q <= `SEEK_RUN_RST;
            cacc_q <= `RATE_RST;
            cdec_q <= `RATE_RST;
        end else begin
            home_go_q <= wr_en && (awaddr_q == `REG_CTRL) && wmerged[`CTRL_GO];
            if (wr_en) begin
                case (awaddr_q)
                    `REG_CTRL: ctrl_q <= {wmerged[4:1], 1'b0};
                    `REG_PRESET: preset_q <= wmerged[23:0];
                    `REG_SEEK_START: vs_q <= wmerged[19:0];
                    `REG_SEEK_RUN: vr_q <= wmerged[19:0];
                    `REG_COMMON_ACC: cacc_q <= wmerged[19:0];
                    `REG_COMMON_DEC: cdec_q <= wmerged[19:0];
                    default: ;
                endcase
            end
        end
    end

    // Speed, acceleration and deceleration per entry
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < N_ENTRIES; i++) begin
                spd_q[i] <= `SPEED_RST;
                acc_q[i] <= `RATE_RST;
                dec_q[i] <= `RATE_RST;
            end
        end else if (wr_en && tbl_hit(awaddr_q)) begin
            case (awaddr_q[3:2])
                2'h0: spd_q[awaddr_q[9:4]] <= wmerged[19:0];
                2'h1: acc_q[awaddr_q[9:4]] <= wmerged[19:0];
                default: dec_q[awaddr_q[9:4]] <= wmerged[19:0];
            endcase
        end
    end

    // ==========================================================
    // Motion state
    state_t state_q;
    logic dir_q, step_q, step_neg_q, home_done_q;
    logic [7:0] steps_q;
    logic [31:0] halt_q;
    logic [19:0] speed_q, run_spd, acc_rate, dec_rate, vl, target;
    logic [20:0] ramp_q, ramp_sum;
    logic [25:0] phase_q, phase_sum;
    logic signed [31:0] pos_q;
    logic want, want_neg, want_same, qual_en, qual_hit, preset_ok;
    logic slot_en, tim_en;

    assign slot_en = ctrl_q[`CTRL_SLOT];
    assign tim_en = ctrl_q[`CTRL_TIM];
    assign run_spd = spd_q[IO_IN.data_select_bits];
    assign acc_rate = ctrl_q[`CTRL_COMMON] ? cacc_q : acc_q[IO_IN.data_select_bits];
    assign dec_rate = ctrl_q[`CTRL_COMMON] ? cdec_q : dec_q[IO_IN.data_select_bits];
    assign vl = (vs_q < `VL_CAP_HZ) ? vs_q : `VL_CAP_HZ;
    // Both inputs at once count as a stop request
    assign want = (IO_IN.forward_run ^ IO_IN.reverse_run) && !IO_IN.alarm;
    assign want_neg = IO_IN.reverse_run;
    assign want_same = want && (want_neg == dir_q);
    assign qual_en = slot_en || tim_en;
    assign qual_hit = qual_en && (!slot_en || IO_IN.slot_sensor_input)
                      && (!tim_en || IO_IN.step_phase_timing);
    assign preset_ok = IO_IN.preset_req && (state_q == S_IDLE) && (speed_q == 20'h0_0000)
                       && !IO_IN.alarm;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= S_IDLE;
            dir_q <= 1'b0;
            steps_q <= 8'h00;
            halt_q <= 32'h0000_0000;
            home_done_q <= 1'b0;
        end else begin
            home_done_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (IO_IN.alarm) begin
                        state_q <= S_IDLE;
                    end else if (home_go_q) begin
                        dir_q <= ctrl_q[`CTRL_NEG];
                        state_q <= S_SEEK;
                    end else if (want) begin
                        dir_q <= want_neg;
                        state_q <= S_RUN;
                    end
                end
                S_RUN: begin
                    // Direction only turns once the motor is at rest
                    if (!want_same && speed_q == 20'h0_0000) begin
                        if (want) begin
                            dir_q <= want_neg;
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_SEEK: begin
                    if (IO_IN.end_hit) begin
                        dir_q <= !dir_q;
                        steps_q <= 8'h00;
                        state_q <= S_BACK;
                    end
                end
                S_BACK: begin
                    if (step_q) begin
                        steps_q <= steps_q + 8'h01;
                        if (steps_q == `BACK_STEPS - 8'h01) begin
                            if (qual_en) begin
                                halt_q <= 32'h0000_0000;
                                state_q <= S_PAUSE;
                            end else begin
                                state_q <= S_IDLE;
                                home_done_q <= 1'b1;
                            end
                        end
                    end
                end
                S_PAUSE: begin
                    halt_q <= halt_q + 32'h0000_0001;
                    if (halt_q >= 32'(HALT_CYCLES - 1)) begin
                        state_q <= S_FIND;
                    end
                end
                S_FIND: begin
                    if (qual_hit) begin
                        state_q <= S_IDLE;
                        home_done_q <= 1'b1;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Speed profile
    assign target = want_same ? run_spd : 20'h0_0000;
    assign ramp_sum = ramp_q + RAMP_STEP;

    // Rate counts are ns per Hz; at most 1 Hz per clock, so rates below 40 saturate
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            speed_q <= 20'h0_0000;
            ramp_q <= 21'h00_0000;
        end else begin
            case (state_q)
                S_RUN: begin
                    if (speed_q == target) begin
                        ramp_q <= 21'h00_0000;
                    end else if (ramp_sum >= {1'b0, (speed_q < target) ? acc_rate : dec_rate}) begin
                        ramp_q <= ramp_sum - {1'b0, (speed_q < target) ? acc_rate : dec_rate};
                        speed_q <= (speed_q < target) ? speed_q + 20'h0_0001
                                                      : speed_q - 20'h0_0001;
                    end else begin
                        ramp_q <= ramp_sum;
                    end
                end
                S_SEEK: speed_q <= vr_q;
                S_BACK: speed_q <= vl;
                S_FIND: speed_q <= vl;
                default: begin
                    speed_q <= 20'h0_0000;
                    ramp_q <= 21'h00_0000;
                end
            endcase
        end
    end

    // ==========================================================
    // Step generator and command position
    assign phase_sum = phase_q + {6'h00, speed_q};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_q <= 26'h000_0000;
            step_q <= 1'b0;
            step_neg_q <= 1'b0;
        end else begin
            step_neg_q <= dir_q;
            if (phase_sum >= PHASE_WRAP) begin
                phase_q <= phase_sum - PHASE_WRAP;
                step_q <= 1'b1;
            end else begin
                phase_q <= phase_sum;
                step_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pos_q <= 32'sh0000_0000;
        end else if (preset_ok) begin
            pos_q <= 32'(preset_q);
        end else if (home_done_q) begin
            pos_q <= 32'sh0000_0000;
        end else if (step_q) begin
            pos_q <= step_neg_q ? pos_q - 32'sh0000_0001 : pos_q + 32'sh0000_0001;
        end
    end

    // ==========================================================
    // Outputs and read mux
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            MOTOR <= '0;
        end else begin
            MOTOR.step <= step_q;
            MOTOR.dir_neg <= dir_q;
            MOTOR.move <= (state_q != S_IDLE) || (speed_q != 20'h0_0000);
            MOTOR.ready <= (state_q == S_IDLE) && (speed_q == 20'h0_0000) && !IO_IN.alarm;
            if (preset_ok || home_done_q) begin
                MOTOR.home_p <= 1'b1;
            end else if (step_q) begin
                MOTOR.home_p <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        case (AXI_REQ.araddr)
            `REG_CTRL: rd_d = {27'h000_0000, ctrl_q};
            `REG_STATUS: rd_d = {25'h000_0000, MOTOR.dir_neg, MOTOR.home_p,
                                 MOTOR.ready, MOTOR.move, state_q};
            `REG_CMD_POS: rd_d = pos_q;
            `REG_PRESET: rd_d = {{8{preset_q[23]}}, preset_q};
            `REG_SEEK_START: rd_d = {12'h000, vs_q};
            `REG_SEEK_RUN: rd_d = {12'h000, vr_q};
            `REG_COMMON_ACC: rd_d = {12'h000, cacc_q};
            `REG_COMMON_DEC: rd_d = {12'h000, cdec_q};
            default: begin
                if (tbl_hit(AXI_REQ.araddr)) begin
                    case (AXI_REQ.araddr[3:2])
                        2'h0: rd_d = {12'h000, spd_q[AXI_REQ.araddr[9:4]]};
                        2'h1: rd_d = {12'h000, acc_q[AXI_REQ.araddr[9:4]]};
                        default: rd_d = {12'h000, dec_q[AXI_REQ.araddr[9:4]]};
                    endcase
                end
            end
        endcase
    end

endmodule

`default_nettype wire

/* File: step_consts.svh */
// Offsets, field positions, reset values and timing figures for the motion block.
// Assumes a 25 MHz core clock and a 12-bit AXI4-Lite byte address.
`ifndef STEP_MOTION_CONSTS_SVH
`define STEP_MOTION_CONSTS_SVH

// ==========================================================
// Timing
`define CLK_HZ 25_000_000
`define CLK_NS 40
`define VL_CAP_HZ 20'h0_01F4
`define BACK_STEPS 8'hC8
`define HALT_MS 10

// ==========================================================
// Register offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_CMD_POS 12'h008
`define REG_PRESET 12'h00C
`define REG_SEEK_START 12'h010
`define REG_SEEK_RUN 12'h014
`define REG_COMMON_ACC 12'h018
`define REG_COMMON_DEC 12'h01C
`define TBL_SEL 2'h1

// ==========================================================
// Control fields
`define CTRL_GO 0
`define CTRL_SLOT 1
`define CTRL_TIM 2
`define CTRL_NEG 3
`define CTRL_COMMON 4

// ==========================================================
// Reset values and responses
`define SPEED_RST 20'h0_03E8
`define RATE_RST 20'h0_03E8
`define SEEK_START_RST 20'h0_01F4
`define SEEK_RUN_RST 20'h0_03E8
`define PRESET_RST 24'h00_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: step_pkg.sv */
// Types shared by the motion block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package step_pkg;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_RUN   = 3'b001,
        S_SEEK  = 3'b010,
        S_BACK  = 3'b011,
        S_PAUSE = 3'b100,
        S_FIND  = 3'b101
    } state_t;

    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic forward_run;
        logic reverse_run;
        logic [5:0] data_select_bits;
        logic preset_req;
        logic alarm;
        logic end_hit;
        logic slot_sensor_input;
        logic step_phase_timing;
    } io_in_t;

    typedef struct packed {
        logic step;
        logic dir_neg;
        logic move;
        logic ready;
        logic home_p;
    } motor_out_t;

endpackage

/* File: step_motion_monitor.sv */
// Port-level checker for the motion sequencer.
// Assumes one clock domain and the bind below.
`timescale 1ns/1ps
`default_nettype none
module step_motion_monitor
import step_pkg::*;
#(
    parameter int unsigned HALT_CYCLES = 20,
    parameter int unsigned N_ENTRIES = 64
) (
    input wire logic CLK, // Core clock
    input wire logic RST_N, // Async reset, active low
    input wire step_pkg::axil_req_t AXI_REQ, // Bus requests
    input wire step_pkg::axil_rsp_t AXI_RSP, // Bus answers
    input wire step_pkg::io_in_t IO_IN, // Discrete inputs
    input wire step_pkg::motor_out_t MOTOR // Motor outputs
);
    // ====
    // Properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_preset_flag: assert property (IO_IN.preset_req && MOTOR.ready && !IO_IN.alarm
        |=> MOTOR.home_p) else $error("preset gave no flag");
    a_preset_block: assert property (IO_IN.alarm && !MOTOR.home_p && !MOTOR.move
        |=> !MOTOR.home_p) else $error("preset taken under alarm");
    a_alarm_ready: assert property (IO_IN.alarm |=> !MOTOR.ready)
        else $error("ready during alarm");
    a_run_start: assert property (MOTOR.ready && (IO_IN.forward_run ^ IO_IN.reverse_run)
        && !IO_IN.alarm |-> ##2 MOTOR.move) else $error("run did not start");
    a_run_dir: assert property (MOTOR.ready && (IO_IN.forward_run ^ IO_IN.reverse_run)
        && !IO_IN.alarm |-> ##2 (MOTOR.dir_neg == $past(IO_IN.reverse_run, 2)))
        else $error("wrong run direction");
    a_step_pulse: assert property (MOTOR.step |=> !MOTOR.step)
        else $error("step wider than one cycle");
    a_ready_still: assert property (MOTOR.ready |-> !MOTOR.step && !MOTOR.move)
        else $error("step while ready");
    a_wr_answer: assert property (AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid
        && AXI_RSP.wready |-> ##2 AXI_RSP.bvalid) else $error("no write response");
    a_rd_hold: assert property (AXI_RSP.rvalid && !AXI_REQ.rready
        |=> AXI_RSP.rvalid && $stable(AXI_RSP.rdata)) else $error("read data dropped");
endmodule
bind step_motion step_motion_monitor #(.HALT_CYCLES(HALT_CYCLES), .N_ENTRIES(N_ENTRIES)) mon (
    .CLK(CLK), .RST_N(RST_N), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP), .IO_IN(IO_IN), .MOTOR(MOTOR));
`default_nettype wire

/* File: host_io_model.sv */
// Host side of the position load handshake.
// Assumes go is a one-cycle pulse from the bench.
`timescale 1ns/1ps
`default_nettype none
module host_io_model (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Reset, active low
    input wire logic ready, // Device ready
    input wire logic home_p, // Device home flag
    input wire logic go, // Start one load
    input wire logic rude, // Skip ready wait, give up after 16 cycles
    output var logic preset_req, // Load request
    output var logic done // One-cycle end mark
);
    // ====
    // Handshake
    logic pend_q;
    logic [3:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            preset_req <= 1'b0;
            pend_q <= 1'b0;
            cnt_q <= 4'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (go) pend_q <= 1'b1;
            if (pend_q && !preset_req && (ready || rude)) begin
                preset_req <= 1'b1;
                pend_q <= 1'b0;
            end else if (preset_req) begin
                cnt_q <= cnt_q + 4'h1;
                // Held until flag seen or 16 cycles pass; rude ignores the flag
                if ((home_p && !rude) || cnt_q == 4'hF) begin
                    preset_req <= 1'b0;
                    done <= 1'b1;
                    cnt_q <= 4'h0;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: step_motion_tb.sv */
// Self-checking bench for the motion sequencer.
// Assumes the monitor bind and the host model beside the block.
`timescale 1ns/1ps
`default_nettype none
`include "step_consts.svh"
module step_motion_tb;
    import step_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    axil_req_t req = '0;
    axil_rsp_t rsp;
    io_in_t io = '0;
    io_in_t io_w;
    motor_out_t mot;
    logic go = 1'b0;
    logic rude = 1'b0;
    logic preq, pdone;
    logic [31:0] rd;
    logic [1:0] rr;
    int miscompares = 0;
    int n_compared = 0;
    int n;
    always #20 clk = ~clk;
    always_comb begin
        io_w = io;
        io_w.preset_req = preq;
    end
    step_motion #(.HALT_CYCLES(20), .N_ENTRIES(64)) dut (.CLK(clk), .RST_N(rst_n),
        .AXI_REQ(req), .AXI_RSP(rsp), .IO_IN(io_w), .MOTOR(mot));
    host_io_model host (.clk(clk), .rst_n(rst_n), .ready(mot.ready), .home_p(mot.home_p),
        .go(go), .rude(rude), .preset_req(preq), .done(pdone));
    // ====
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
    endtask
    task automatic rdr(input logic [11:0] a);
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        rd = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        rdr(a);
        chk(rd, e);
    endtask
    // Direction bit over state code
    task automatic st(input logic [3:0] e);
        rdr(`REG_STATUS);
        chk({28'h0, rd[6], rd[2:0]}, {28'h0, e});
    endtask
    task automatic idle_wait;
        n = 0;
        while (mot.move !== 1'b0) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic load;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge pdone);
    endtask
    task automatic final_report;
        $display("miscompares %0d n_compared %0d", miscompares, n_compared);
        if (miscompares == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #4_000_000;
        miscompares++;
        final_report;
    end
    // ====
    // Tests
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rchk(`REG_PRESET, 32'h0000_0000);
        rchk(12'h400, 32'h0000_03E8);
        rchk(12'h7F4, 32'h0000_03E8);
        rchk(12'h408, 32'h0000_03E8);
        rdr(12'h40C);
        chk({30'h0, rr}, 32'h0000_0002);
        wr(`REG_PRESET, 32'h007F_FFFF);
        io.alarm <= 1'b1;
        rude <= 1'b1;
        load;
        rchk(`REG_CMD_POS, 32'h0000_0000);
        io.alarm <= 1'b0;
        rude <= 1'b0;
        wr(`REG_PRESET, 32'h0080_0000);
        rchk(`REG_PRESET, 32'hFF80_0000);
        load;
        chk({31'h0, mot.home_p}, 32'h0000_0001);
        rchk(`REG_CMD_POS, 32'hFF80_0000);
        wr(12'h400, 32'h0000_0190);
        wr(12'h404, 32'h0000_0001);
        wr(12'h408, 32'h0000_0001);
        wr(12'h410, 32'h0000_0320);
        wr(12'h414, 32'h0000_0001);
        wr(12'h418, 32'h0000_0001);
        io.forward_run <= 1'b1;
        repeat (4) @(posedge clk);
        st(4'h1);
        io.data_select_bits <= 6'h01;
        repeat (500) @(posedge clk);
        st(4'h1);
        io.forward_run <= 1'b0;
        repeat (20) @(posedge clk);
        io.forward_run <= 1'b1;
        repeat (20) @(posedge clk);
        st(4'h1);
        io.forward_run <= 1'b0;
        idle_wait;
        chk({31'h0, n < 2000}, 32'h0000_0001);
        chk({31'h0, n > 450}, 32'h0000_0001);
        io.data_select_bits <= 6'h00;
        io.reverse_run <= 1'b1;
        repeat (4) @(posedge clk);
        st(4'h9);
        repeat (200) @(posedge clk);
        io.forward_run <= 1'b1;
        idle_wait;
        chk({31'h0, n < 2000}, 32'h0000_0001);
        io.forward_run <= 1'b0;
        io.reverse_run <= 1'b0;
        wr(`REG_CTRL, 32'h0000_0010);
        wr(`REG_COMMON_ACC, 32'h0000_0001);
        io.forward_run <= 1'b1;
        repeat (400) @(posedge clk);
        io.forward_run <= 1'b0;
        idle_wait;
        chk({31'h0, n > 5000}, 32'h0000_0001);
        wr(`REG_CTRL, 32'h0000_0003);
        repeat (4) @(posedge clk);
        st(4'h2);
        io.end_hit <= 1'b1;
        repeat (4) @(posedge clk);
        st(4'hB);
        rst_n <= 1'b0;
        io.end_hit <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({31'h0, mot.ready}, 32'h0000_0001);
        final_report;
    end
endmodule
`default_nettype wire
